// File: rtl/ebx_pkg.sv
// Overview of operation
// - Far skip: three cycles skipping, else two
// - Far write to counter low byte: three cycles
// - Page table read loads high register, memory
// - Final page table read, three cycles
// - Preincrement variants bump pointer before reading
// - Null/nonnull skip tests whole byte, flags kept
// - Skip-move copies byte to accumulator, skips null
// - Bit skip tests one selected bit
// - Incr/decr skip writes back, skips null
// - Accumulator variants load accumulator, still skip
// - Nibble exchange to memory or accumulator
// - Add with carry into accumulator, five flags
// - Add with carry into memory, five flags
// - Plain add into accumulator, five flags
// - Immediate add into accumulator, five flags
// - Plain add into memory, five flags
// - Memory AND to accumulator or memory, zero flag
// - Immediate AND into accumulator, zero flag only
// - Far instructions address every memory sector directly
package ebx_pkg;

	// ****************************************
	// Widths, addresses and reset values
	// ****************************************
	localparam int DM_AW = 10;
	localparam int PM_AW = 16;
	localparam int PM_DW = 16;
	localparam logic [DM_AW-1:0] PCL_ADDR = 10'h007;
	localparam logic [7:0] FINAL_PAGE = 8'hff;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] TABLE_POINTER_REG_RST = 8'h00;
	localparam logic [7:0] TABLE_HIGH_BYTE_REG_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_FAR_SKIP_IF_NULL = 5'h01,
		OP_FAR_SKIP_NULL_MOVE_TO_ACC = 5'h02,
		OP_FAR_SKIP_IF_NONNULL = 5'h03,
		OP_FAR_SKIP_BIT_NULL = 5'h04,
		OP_FAR_SKIP_BIT_NONNULL = 5'h05,
		OP_FAR_INCR_SKIP_IF_NULL = 5'h06,
		OP_FAR_DECR_SKIP_IF_NULL = 5'h07,
		OP_FAR_INCR_SKIP_NULL_TO_ACC = 5'h08,
		OP_FAR_DECR_SKIP_NULL_TO_ACC = 5'h09,
		OP_FAR_TABLE_READ_PAGE = 5'h0a,
		OP_FAR_TABLE_READ_FINAL_PAGE = 5'h0b,
		OP_FAR_PREINC_TABLE_READ_PAGE = 5'h0c,
		OP_FAR_PREINC_TABLE_READ_FINAL = 5'h0d,
		OP_FAR_ZERO_BYTE = 5'h0e,
		OP_FAR_ONES_BYTE = 5'h0f,
		OP_FAR_NIBBLE_EXCHANGE = 5'h10,
		OP_FAR_NIBBLE_EXCHANGE_TO_ACC = 5'h11,
		OP_ADD_WITH_CARRY_TO_ACC = 5'h12,
		OP_ADD_WITH_CARRY_TO_MEM = 5'h13,
		OP_PLAIN_SUM_TO_ACC = 5'h14,
		OP_PLAIN_SUM_IMM = 5'h15,
		OP_PLAIN_SUM_TO_MEM = 5'h16,
		OP_BITWISE_CONJ_TO_ACC = 5'h17,
		OP_BITWISE_CONJ_IMM = 5'h18,
		OP_BITWISE_CONJ_TO_MEM = 5'h19
	} ebx_op_e;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_READ = 6'b000010,
		ST_TPTR = 6'b000100,
		ST_PMRD = 6'b001000,
		ST_WB = 6'b010000,
		ST_FLUSH = 6'b100000
	} ebx_state_e;

	typedef struct packed {
		logic ov;
		logic sc;
		logic ac;
		logic c;
		logic z;
	} ebx_flags_s;

	typedef struct packed {
		ebx_op_e op;
		logic [DM_AW-1:0] addr;
		logic [2:0] bsel;
		logic [7:0] imm;
	} ebx_instr_s;

	typedef struct packed {
		logic [DM_AW-1:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} ebx_dm_req_s;

	typedef struct packed {
		logic [7:0] res;
		ebx_flags_s fl;
	} ebx_alu_s;

	typedef struct packed {
		ebx_state_e st;
		ebx_instr_s ins;
		logic [7:0] acc;
		ebx_flags_s fl;
		logic [7:0] table_pointer_reg;
		logic [7:0] table_high_byte_reg;
		ebx_dm_req_s dm;
		logic [PM_AW-1:0] pm_addr;
		logic pm_rd;
		logic busy;
		logic done;
		logic skip;
		logic refetch;
		logic pend_skip;
		logic pend_ref;
	} ebx_state_s;

endpackage

// File: rtl/ebx_alu.sv
`timescale 1ns/100ps
module ebx_alu
	import ebx_pkg::*;
(
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	output ebx_alu_s out_o
);

	logic [4:0] low_sum;
	logic [3:0] mid_sum;
	logic [1:0] top_sum;
	logic [7:0] res;

	// ****************************************
	// Adder split at nibble and sign bit
	// ****************************************
	assign low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
	assign mid_sum = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, low_sum[4]};
	assign top_sum = {1'b0, a_i[7]} + {1'b0, b_i[7]} + {1'b0, mid_sum[3]};
	assign res = {top_sum[0], mid_sum[2:0], low_sum[3:0]};

	// Result and five arithmetic flags
	assign out_o.res = res;
	assign out_o.fl.c = top_sum[1];
	assign out_o.fl.ac = low_sum[4];
	assign out_o.fl.ov = mid_sum[3] ^ top_sum[1];
	assign out_o.fl.sc = top_sum[0] ^ mid_sum[3] ^ top_sum[1];
	assign out_o.fl.z = (res == BYTE_ZERO);

endmodule

// File: rtl/ebx_exec.sv
`timescale 1ns/100ps
module ebx_exec
	import ebx_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire ebx_instr_s instr_i,
	input wire logic [7:0] table_page_i,
	input wire logic [7:0] dm_rdata_i,
	input wire logic [PM_DW-1:0] pm_rdata_i,
	output ebx_dm_req_s dm_o,
	output logic [PM_AW-1:0] pm_addr_o,
	output logic pm_rd_o,
	output logic [7:0] acc_o,
	output ebx_flags_s flags_o,
	output logic [7:0] table_pointer_reg_o,
	output logic [7:0] table_high_byte_reg_o,
	output logic busy_o,
	output logic done_o,
	output logic skip_o,
	output logic refetch_o
);

	ebx_state_s s;
	ebx_state_s n;
	ebx_alu_s alu;
	logic [7:0] rd;
	logic [7:0] alu_b;
	logic alu_cin;
	logic [7:0] rd_inc;
	logic [7:0] rd_dec;
	logic [7:0] rd_swap;
	logic [7:0] conj_v;
	logic [7:0] table_pointer_reg_next;
	logic [7:0] page_sel;
	logic is_table;
	logic is_preinc;
	logic is_final;
	logic [7:0] bit_hit;
	logic bit_set;

	// ****************************************
	// Operand preparation
	// ****************************************
	assign rd = dm_rdata_i;
	assign rd_inc = rd + BYTE_ONE;
	assign rd_dec = rd - BYTE_ONE;
	assign rd_swap = {rd[3:0], rd[7:4]};

	// Immediate forms take the operand from the instruction
	assign alu_b = (s.ins.op == OP_PLAIN_SUM_IMM) ? s.ins.imm : rd;
	assign alu_cin = (s.ins.op == OP_ADD_WITH_CARRY_TO_ACC || s.ins.op == OP_ADD_WITH_CARRY_TO_MEM) ? s.fl.c : 1'b0;
	assign conj_v = s.acc & ((s.ins.op == OP_BITWISE_CONJ_IMM) ? s.ins.imm : rd);

	// Selected bit of the operand, one lane per bit
	for (genvar i = 0; i < 8; i++)
	begin : g_bit_sel
		assign bit_hit[i] = (s.ins.bsel == 3'(i)) && rd[i];
	end
	assign bit_set = |bit_hit;

	// ****************************************
	// Table read decode
	// ****************************************
	// Issue decode looks at the incoming word, not the held one
	always_comb
	begin
		is_table = 1'b0;
		unique case (instr_i.op)
			OP_FAR_TABLE_READ_PAGE,
			OP_FAR_TABLE_READ_FINAL_PAGE,
			OP_FAR_PREINC_TABLE_READ_PAGE,
			OP_FAR_PREINC_TABLE_READ_FINAL:
			begin
				is_table = 1'b1;
			end
			default:
			begin
				is_table = 1'b0;
			end
		endcase
	end

	// Pointer bump and page choice of the held table read
	always_comb
	begin
		is_preinc = 1'b0;
		is_final = 1'b0;
		unique case (s.ins.op)
			OP_FAR_TABLE_READ_FINAL_PAGE:
			begin
				is_final = 1'b1;
			end
			OP_FAR_PREINC_TABLE_READ_PAGE:
			begin
				is_preinc = 1'b1;
			end
			OP_FAR_PREINC_TABLE_READ_FINAL:
			begin
				is_preinc = 1'b1;
				is_final = 1'b1;
			end
			default:
			begin
				is_preinc = 1'b0;
				is_final = 1'b0;
			end
		endcase
	end

	// Pointer and page for the table word
	assign table_pointer_reg_next = is_preinc ? s.table_pointer_reg + BYTE_ONE : s.table_pointer_reg;
	assign page_sel = is_final ? FINAL_PAGE : table_page_i;

	// ****************************************
	// Adder
	// ****************************************
	ebx_alu u_alu (
		.a_i(s.acc),
		.b_i(alu_b),
		.cin_i(alu_cin),
		.out_o(alu)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		n = s;
		n.done = 1'b0;
		n.skip = 1'b0;
		n.refetch = 1'b0;
		n.dm.rd = 1'b0;
		n.dm.wr = 1'b0;
		n.pm_rd = 1'b0;
		unique case (s.st)
			ST_IDLE:
			begin
				if (start_i)
				begin
					n.ins = instr_i;
					n.busy = 1'b1;
					n.pend_skip = 1'b0;
					n.pend_ref = 1'b0;
					if (is_table)
					begin
						n.st = ST_TPTR;
					end
					else
					begin
						n.st = ST_READ;
						n.dm.addr = instr_i.addr;
						n.dm.rd = 1'b1;
					end
				end
			end
			ST_READ:
			begin
				n.st = ST_WB;
				n.dm.wdata = rd;
				// Flags left alone unless the op is arithmetic or logic
				unique case (s.ins.op)
					OP_FAR_SKIP_IF_NULL:
					begin
						n.pend_skip = (rd == BYTE_ZERO);
					end
					OP_FAR_SKIP_NULL_MOVE_TO_ACC:
					begin
						n.acc = rd;
						n.pend_skip = (rd == BYTE_ZERO);
					end
					OP_FAR_SKIP_IF_NONNULL:
					begin
						n.pend_skip = (rd != BYTE_ZERO);
					end
					OP_FAR_SKIP_BIT_NULL:
					begin
						n.pend_skip = ~bit_set;
					end
					OP_FAR_SKIP_BIT_NONNULL:
					begin
						n.pend_skip = bit_set;
					end
					OP_FAR_INCR_SKIP_IF_NULL:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = rd_inc;
						n.pend_skip = (rd_inc == BYTE_ZERO);
					end
					OP_FAR_DECR_SKIP_IF_NULL:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = rd_dec;
						n.pend_skip = (rd_dec == BYTE_ZERO);
					end
					OP_FAR_INCR_SKIP_NULL_TO_ACC:
					begin
						n.acc = rd_inc;
						n.pend_skip = (rd_inc == BYTE_ZERO);
					end
					OP_FAR_DECR_SKIP_NULL_TO_ACC:
					begin
						n.acc = rd_dec;
						n.pend_skip = (rd_dec == BYTE_ZERO);
					end
					OP_FAR_ZERO_BYTE:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = BYTE_ZERO;
					end
					OP_FAR_ONES_BYTE:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = BYTE_ONES;
					end
					OP_FAR_NIBBLE_EXCHANGE:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = rd_swap;
					end
					OP_FAR_NIBBLE_EXCHANGE_TO_ACC:
					begin
						n.acc = rd_swap;
					end
					OP_ADD_WITH_CARRY_TO_ACC:
					begin
						n.acc = alu.res;
						n.fl = alu.fl;
					end
					OP_ADD_WITH_CARRY_TO_MEM:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = alu.res;
						n.fl = alu.fl;
					end
					OP_PLAIN_SUM_TO_ACC:
					begin
						n.acc = alu.res;
						n.fl = alu.fl;
					end
					OP_PLAIN_SUM_IMM:
					begin
						n.acc = alu.res;
						n.fl = alu.fl;
					end
					OP_PLAIN_SUM_TO_MEM:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = alu.res;
						n.fl = alu.fl;
					end
					OP_BITWISE_CONJ_TO_ACC:
					begin
						n.acc = conj_v;
						n.fl.z = (conj_v == BYTE_ZERO);
					end
					OP_BITWISE_CONJ_IMM:
					begin
						n.acc = conj_v;
						n.fl.z = (conj_v == BYTE_ZERO);
					end
					OP_BITWISE_CONJ_TO_MEM:
					begin
						n.dm.wr = 1'b1;
						n.dm.wdata = conj_v;
						n.fl.z = (conj_v == BYTE_ZERO);
					end
					default:
					begin
						n.pend_skip = 1'b0;
					end
				endcase
				// Writing the counter low byte forces a refetch cycle
				n.pend_ref = n.dm.wr && (s.dm.addr == PCL_ADDR);
			end
			ST_TPTR:
			begin
				n.table_pointer_reg = table_pointer_reg_next;
				n.pm_addr = {page_sel, table_pointer_reg_next};
				n.pm_rd = 1'b1;
				n.st = ST_PMRD;
			end
			ST_PMRD:
			begin
				n.table_high_byte_reg = pm_rdata_i[15:8];
				n.dm.addr = s.ins.addr;
				n.dm.wdata = pm_rdata_i[7:0];
				n.dm.wr = 1'b1;
				n.st = ST_WB;
			end
			ST_WB:
			begin
				// Flush cycle only when skipping or refetching
				if (s.pend_skip || s.pend_ref)
				begin
					n.st = ST_FLUSH;
					n.skip = s.pend_skip;
					n.refetch = s.pend_ref;
				end
				else
				begin
					n.st = ST_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
			ST_FLUSH:
			begin
				n.st = ST_IDLE;
				n.busy = 1'b0;
				n.done = 1'b1;
			end
			default:
			begin
				n.st = ST_IDLE;
				n.busy = 1'b0;
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			s <= '0;
			s.st <= ST_IDLE;
			s.acc <= ACC_RST;
			s.table_pointer_reg <= TABLE_POINTER_REG_RST;
			s.table_high_byte_reg <= TABLE_HIGH_BYTE_REG_RST;
		end
		else
		begin
			s <= n;
		end
	end

	// ****************************************
	// Outputs straight from state
	// ****************************************
	assign dm_o = s.dm;
	assign pm_addr_o = s.pm_addr;
	assign pm_rd_o = s.pm_rd;
	assign acc_o = s.acc;
	assign flags_o = s.fl;
	assign table_pointer_reg_o = s.table_pointer_reg;
	assign table_high_byte_reg_o = s.table_high_byte_reg;
	assign busy_o = s.busy;
	assign done_o = s.done;
	assign skip_o = s.skip;
	assign refetch_o = s.refetch;

endmodule

// File: tb/ebx_checker.sv
`timescale 1ns/100ps
module ebx_checker
	import ebx_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [PM_DW-1:0] pm_rdata_i,
	input wire ebx_dm_req_s dm_o,
	input wire logic pm_rd_o,
	input wire logic [7:0] acc_o,
	input wire ebx_flags_s flags_o,
	input wire logic [7:0] table_high_byte_reg_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic skip_o,
	input wire logic refetch_o
);
	// ****************************************
	// Timing and flag properties
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_skip; skip_o |-> busy_o ##1 (done_o && !busy_o); endproperty
	a_skip: assert property (p_skip) else $error("skip cycle misplaced");
	property p_len; $rose(busy_o) |=> busy_o ##[1:2] $fell(busy_o); endproperty
	a_len: assert property (p_len) else $error("instruction length wrong");
	property p_ref; refetch_o |-> busy_o ##1 done_o; endproperty
	a_ref: assert property (p_ref) else $error("refetch cycle misplaced");
	property p_tbl; pm_rd_o |=> dm_o.wr && dm_o.wdata == $past(pm_rdata_i[7:0])
		&& table_high_byte_reg_o == $past(pm_rdata_i[15:8]) ##1 done_o; endproperty
	a_tbl: assert property (p_tbl) else $error("table word split wrong");
	property p_tflag; pm_rd_o |-> $stable(flags_o) && $stable(acc_o) ##1 $stable(flags_o); endproperty
	a_tflag: assert property (p_tflag) else $error("table read touched flags");
	property p_sflag; skip_o |-> flags_o == $past(flags_o, 2); endproperty
	a_sflag: assert property (p_sflag) else $error("skip touched flags");
	property p_zmem; dm_o.wr && $changed(flags_o) |-> flags_o.z == (dm_o.wdata == 8'h00); endproperty
	a_zmem: assert property (p_zmem) else $error("zero flag wrong on write");
	property p_zacc; $changed(acc_o) && $changed(flags_o) |-> flags_o.z == (acc_o == 8'h00); endproperty
	a_zacc: assert property (p_zacc) else $error("zero flag wrong on acc");
endmodule

// File: tb/ebx_exec_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module ebx_exec_tb
	import ebx_pkg::*;
();
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic start_i = 1'b0;
	ebx_instr_s instr_i = '0;
	logic [7:0] table_page_i = 8'h00;
	logic [7:0] dm_rdata_i;
	logic [PM_DW-1:0] pm_rdata_i;
	ebx_dm_req_s dm_o;
	logic [PM_AW-1:0] pm_addr_o;
	logic pm_rd_o, busy_o, done_o, skip_o, refetch_o, sk, rf;
	logic [7:0] acc_o, table_pointer_reg, table_high_byte_reg;
	ebx_flags_s flags_o;
	logic [7:0] mem [0:1023];
	int failures = 0;
	int check_count = 0;
	int cyc;

	ebx_exec ebx_exec_inst (.ref_clk_i, .rst_n_i, .start_i, .instr_i, .table_page_i, .dm_rdata_i,
		.pm_rdata_i, .dm_o, .pm_addr_o, .pm_rd_o, .acc_o, .flags_o, .table_pointer_reg_o(table_pointer_reg),
		.table_high_byte_reg_o(table_high_byte_reg), .busy_o, .done_o, .skip_o, .refetch_o);

	// ****************************************
	// Clock and memories
	// ****************************************
	// Free running clock
	initial forever #5 ref_clk_i = ~ref_clk_i;
	// Async data read; program word derived from its address
	assign dm_rdata_i = mem[dm_o.addr];
	assign pm_rdata_i = {pm_addr_o[7:0], ~pm_addr_o[15:8]};
	// Data memory write port
	always @(posedge ref_clk_i) if (dm_o.wr === 1'b1) mem[dm_o.addr] <= dm_o.wdata;

	// ****************************************
	// Tasks
	// ****************************************
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One instruction, counting busy cycles and noting skip and refetch pulses
	task run(input ebx_op_e op, input logic [9:0] a, input logic [2:0] b, input logic [7:0] x);
		@(posedge ref_clk_i);
		start_i <= 1'b1;
		instr_i <= '{op, a, b, x};
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		#1;
		cyc = 0;
		sk = 0;
		rf = 0;
		while (busy_o === 1'b1 && cyc < 8)
		begin
			cyc++;
			sk |= (skip_o === 1'b1);
			rf |= (refetch_o === 1'b1);
			@(posedge ref_clk_i);
			#1;
		end
		`CHK("done", 1'b1, done_o)
		if (cyc >= 8)
		begin
			failures++;
			finish_test();
		end
	endtask

	task t_skip;
		mem[10'h301] = 8'h00;
		mem[10'h3f0] = 8'hf7;
		run(OP_FAR_SKIP_IF_NULL, 10'h301, 3'h0, 8'h00);
		`CHK("len", 3, cyc)
		`CHK("skip", 1'b1, sk)
		run(OP_FAR_SKIP_IF_NONNULL, 10'h301, 3'h0, 8'h00);
		`CHK("len", 2, cyc)
		`CHK("skip", 1'b0, sk)
		run(OP_FAR_SKIP_BIT_NULL, 10'h3f0, 3'h3, 8'h00);
		`CHK("skip", 1'b1, sk)
		run(OP_FAR_SKIP_BIT_NONNULL, 10'h3f0, 3'h2, 8'h00);
		`CHK("skip", 1'b1, sk)
		run(OP_FAR_SKIP_BIT_NONNULL, 10'h3f0, 3'h3, 8'h00);
		`CHK("skip", 1'b0, sk)
		`CHK("flags", 5'h00, flags_o)
		$display("test skip done");
	endtask

	task t_arith;
		mem[10'h202] = 8'h7f;
		mem[10'h1a0] = 8'h80;
		mem[10'h0a5] = 8'h8f;
		mem[10'h0a6] = 8'hf0;
		mem[10'h0a7] = 8'h0f;
		run(OP_FAR_SKIP_NULL_MOVE_TO_ACC, 10'h202, 3'h0, 8'h00);
		`CHK("acc", 8'h7f, acc_o)
		run(OP_PLAIN_SUM_IMM, 10'h000, 3'h0, 8'h01);
		`CHK("acc", 8'h80, acc_o)
		`CHK("flags", 5'h14, flags_o)
		run(OP_ADD_WITH_CARRY_TO_MEM, 10'h1a0, 3'h0, 8'h00);
		`CHK("mem", 8'h00, mem[10'h1a0])
		`CHK("flags", 5'h1b, flags_o)
		run(OP_ADD_WITH_CARRY_TO_ACC, 10'h1a0, 3'h0, 8'h00);
		`CHK("acc", 8'h81, acc_o)
		`CHK("flags", 5'h08, flags_o)
		run(OP_PLAIN_SUM_TO_ACC, 10'h0a5, 3'h0, 8'h00);
		`CHK("acc", 8'h10, acc_o)
		`CHK("flags", 5'h1e, flags_o)
		run(OP_PLAIN_SUM_TO_MEM, 10'h0a6, 3'h0, 8'h00);
		`CHK("mem", 8'h00, mem[10'h0a6])
		`CHK("flags", 5'h03, flags_o)
		run(OP_BITWISE_CONJ_IMM, 10'h000, 3'h0, 8'h30);
		`CHK("acc", 8'h10, acc_o)
		`CHK("flags", 5'h02, flags_o)
		run(OP_BITWISE_CONJ_TO_MEM, 10'h0a7, 3'h0, 8'h00);
		`CHK("mem", 8'h00, mem[10'h0a7])
		`CHK("flags", 5'h03, flags_o)
		run(OP_BITWISE_CONJ_TO_ACC, 10'h0a7, 3'h0, 8'h00);
		`CHK("acc", 8'h00, acc_o)
		$display("test arith done");
	endtask

	task t_incr;
		mem[10'h2ff] = 8'hff;
		mem[10'h300] = 8'h01;
		run(OP_FAR_INCR_SKIP_IF_NULL, 10'h2ff, 3'h0, 8'h00);
		`CHK("mem", 8'h00, mem[10'h2ff])
		`CHK("len", 3, cyc)
		run(OP_FAR_DECR_SKIP_IF_NULL, 10'h2ff, 3'h0, 8'h00);
		`CHK("mem", 8'hff, mem[10'h2ff])
		`CHK("len", 2, cyc)
		run(OP_FAR_DECR_SKIP_NULL_TO_ACC, 10'h300, 3'h0, 8'h00);
		`CHK("acc", 8'h00, acc_o)
		`CHK("skip", 1'b1, sk)
		run(OP_FAR_INCR_SKIP_NULL_TO_ACC, 10'h300, 3'h0, 8'h00);
		`CHK("acc", 8'h02, acc_o)
		`CHK("mem", 8'h01, mem[10'h300])
		`CHK("flags", 5'h03, flags_o)
		$display("test incr done");
	endtask

	task t_misc;
		mem[10'h155] = 8'ha5;
		run(OP_FAR_NIBBLE_EXCHANGE, 10'h155, 3'h0, 8'h00);
		`CHK("mem", 8'h5a, mem[10'h155])
		run(OP_FAR_NIBBLE_EXCHANGE_TO_ACC, 10'h155, 3'h0, 8'h00);
		`CHK("acc", 8'ha5, acc_o)
		`CHK("len", 2, cyc)
		run(OP_FAR_ONES_BYTE, PCL_ADDR, 3'h0, 8'h00);
		`CHK("len", 3, cyc)
		`CHK("refetch", 1'b1, rf)
		run(OP_FAR_ZERO_BYTE, 10'h155, 3'h0, 8'h00);
		`CHK("mem", 8'h00, mem[10'h155])
		`CHK("flags", 5'h03, flags_o)
		$display("test misc done");
	endtask

	task t_table;
		@(posedge ref_clk_i);
		table_page_i <= 8'h12;
		run(OP_FAR_PREINC_TABLE_READ_FINAL, 10'h3c0, 3'h0, 8'h00);
		`CHK("table_pointer_reg", 8'h01, table_pointer_reg)
		`CHK("table_high_byte_reg", 8'h01, table_high_byte_reg)
		`CHK("mem", 8'h00, mem[10'h3c0])
		run(OP_FAR_PREINC_TABLE_READ_PAGE, 10'h3c1, 3'h0, 8'h00);
		`CHK("table_high_byte_reg", 8'h02, table_high_byte_reg)
		`CHK("mem", 8'hed, mem[10'h3c1])
		`CHK("len", 3, cyc)
		run(OP_FAR_TABLE_READ_FINAL_PAGE, 10'h3c2, 3'h0, 8'h00);
		`CHK("table_pointer_reg", 8'h02, table_pointer_reg)
		`CHK("mem", 8'h00, mem[10'h3c2])
		run(OP_FAR_TABLE_READ_PAGE, 10'h3c3, 3'h0, 8'h00);
		`CHK("table_pointer_reg", 8'h02, table_pointer_reg)
		`CHK("mem", 8'hed, mem[10'h3c3])
		$display("test table done");
	endtask

	// Reset between instructions while idle, then a table read from the cleared pointer
	task t_reset;
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		run(OP_FAR_PREINC_TABLE_READ_PAGE, 10'h3c4, 3'h0, 8'h00);
		`CHK("table_pointer_reg", 8'h01, table_pointer_reg)
		`CHK("table_high_byte_reg", 8'h01, table_high_byte_reg)
		`CHK("mem", 8'hed, mem[10'h3c4])
		`CHK("flags", 5'h00, flags_o)
		`CHK("acc", 8'h00, acc_o)
		$display("test reset done");
	endtask

	// Reset, then scenarios
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h33;
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_skip();
		t_arith();
		t_incr();
		t_misc();
		t_table();
		t_reset();
		finish_test();
	end
endmodule

bind ebx_exec ebx_checker ebx_checker_inst (.ref_clk_i, .rst_n_i, .pm_rdata_i, .dm_o, .pm_rd_o,
	.acc_o, .flags_o, .table_high_byte_reg_o, .busy_o, .done_o, .skip_o, .refetch_o);
